// ### cirq_map.svh
// register offsets, field positions and reset values of the irq/filter block
`ifndef CIRQ_MAP_SVH
`define CIRQ_MAP_SVH

// ============================================================
// register byte offsets
`define CIRQ_OFF_FLAG_REG      8'h50
`define CIRQ_OFF_ENABLE_MASK   8'h54
`define CIRQ_OFF_LINE_SELECT   8'h58
`define CIRQ_OFF_LINE_MASTER   8'h5C
`define CIRQ_OFF_GLOBAL_FILT   8'h80
`define CIRQ_OFF_CORE_CTRL     8'h18

// ============================================================
// field layout
`define CIRQ_FLAG_MASK         32'h3FFF_FFFF
`define CIRQ_LINE_EN_MASK      32'h0000_0003
`define CIRQ_FILT_MASK         32'h0000_003F
`define CIRQ_CTRL_MASK         32'h0000_0003
`define CIRQ_CTRL_INIT_BIT     0
`define CIRQ_CTRL_CCE_BIT      1
`define CIRQ_FILT_NM_STD_LO    4
`define CIRQ_FILT_NM_EXT_LO    2
`define CIRQ_FILT_REJ_STD_BIT  1
`define CIRQ_FILT_REJ_EXT_BIT  0
`define CIRQ_RESET_VALUE       32'h0000_0000

`endif

// ### cirq_pkg.sv
// types shared by the irq routing / global filter block
package cirq_pkg;

  // ============================================================
  // where a frame ends up
  typedef enum logic [1:0] {
    CIRQ_STORE_FIFO0,
    CIRQ_STORE_FIFO1,
    CIRQ_DISCARD
  } cirq_dest_e;

  // ============================================================
  // frame presented to the global filter decision
  typedef struct packed {
    logic valid;
    logic extended;
    logic remote;
    logic matched;
    logic match_fifo1;
  } cirq_frame_s;

  typedef struct packed {
    logic       valid;
    cirq_dest_e dest;
  } cirq_verdict_s;

endpackage : cirq_pkg

// ### cirq_top.sv
// interrupt enable, line routing and global filter settings of a can core
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "cirq_map.svh"

module cirq_top #(
  parameter int FLAGS = 30
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // classic wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       wb_err_o,
  // event pulses from the protocol core, same clock
  input  wire logic [FLAGS-1:0]      flag_set_i,
  // frame to classify
  input  wire cirq_pkg::cirq_frame_s frame_i,
  output cirq_pkg::cirq_verdict_s    verdict_o,
  output logic                       irq_line0_o,
  output logic                       irq_line1_o
);

  // ============================================================
  // bus decode
  logic        req;
  logic        wr;
  logic        hit;
  logic [31:0] wmask;

  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign wr    = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] msk);
    merge = ((old & ~wmask) | (wb_dat_i & wmask)) & msk;
  endfunction : merge

  function automatic logic sel(input logic [7:0] off);
    sel = (wb_adr_i == off);
  endfunction : sel

  assign hit = sel(`CIRQ_OFF_FLAG_REG) || sel(`CIRQ_OFF_ENABLE_MASK) ||
               sel(`CIRQ_OFF_LINE_SELECT) || sel(`CIRQ_OFF_LINE_MASTER) ||
               sel(`CIRQ_OFF_GLOBAL_FILT) || sel(`CIRQ_OFF_CORE_CTRL);

  // ============================================================
  // registers
  logic [31:0] irq_flag_register_q;
  logic [31:0] irq_enable_mask_q;
  logic [31:0] irq_line_select_q;
  logic [31:0] irq_line_master_enable_q;
  logic [31:0] global_filter_config_q;
  logic [31:0] ctrl_q;
  logic        config_change_enable;
  logic        initialisation_bit;

  assign initialisation_bit   = ctrl_q[`CIRQ_CTRL_INIT_BIT];
  assign config_change_enable = ctrl_q[`CIRQ_CTRL_CCE_BIT];

  logic [31:0] flag_set_w;
  assign flag_set_w = {{(32-FLAGS){1'b0}}, flag_set_i} & `CIRQ_FLAG_MASK;

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_flag_register_q <= `CIRQ_RESET_VALUE;
    end else begin
      if (wr && sel(`CIRQ_OFF_FLAG_REG)) begin
        irq_flag_register_q <= ((irq_flag_register_q &
                                 ~(wb_dat_i & wmask)) | flag_set_w);
      end else begin
        irq_flag_register_q <= irq_flag_register_q | flag_set_w;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_enable_mask_q <= `CIRQ_RESET_VALUE;
    end else if (wr && sel(`CIRQ_OFF_ENABLE_MASK)) begin
      irq_enable_mask_q <= merge(irq_enable_mask_q, `CIRQ_FLAG_MASK);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_line_select_q <= `CIRQ_RESET_VALUE;
    end else if (wr && sel(`CIRQ_OFF_LINE_SELECT)) begin
      irq_line_select_q <= merge(irq_line_select_q, `CIRQ_FLAG_MASK);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_line_master_enable_q <= `CIRQ_RESET_VALUE;
    end else if (wr && sel(`CIRQ_OFF_LINE_MASTER)) begin
      irq_line_master_enable_q <= merge(irq_line_master_enable_q,
                                        `CIRQ_LINE_EN_MASK);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `CIRQ_RESET_VALUE;
    end else if (wr && sel(`CIRQ_OFF_CORE_CTRL)) begin
      ctrl_q <= merge(ctrl_q, `CIRQ_CTRL_MASK);
    end
  end

  // locked writes are acked but dropped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      global_filter_config_q <= `CIRQ_RESET_VALUE;
    end else if (wr && sel(`CIRQ_OFF_GLOBAL_FILT) &&
                 config_change_enable && initialisation_bit) begin
      global_filter_config_q <= merge(global_filter_config_q,
                                      `CIRQ_FILT_MASK);
    end
  end

  // ============================================================
  // bus answer: one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        unique case (1'b1)
          sel(`CIRQ_OFF_FLAG_REG):    wb_dat_o <= irq_flag_register_q;
          sel(`CIRQ_OFF_ENABLE_MASK): wb_dat_o <= irq_enable_mask_q;
          sel(`CIRQ_OFF_LINE_SELECT): wb_dat_o <= irq_line_select_q;
          sel(`CIRQ_OFF_LINE_MASTER): wb_dat_o <= irq_line_master_enable_q;
          sel(`CIRQ_OFF_GLOBAL_FILT): wb_dat_o <= global_filter_config_q;
          sel(`CIRQ_OFF_CORE_CTRL):   wb_dat_o <= ctrl_q;
          default:                    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ============================================================
  // interrupt routing
  logic [31:0] pending;
  assign pending = irq_flag_register_q & irq_enable_mask_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_line0_o <= 1'b0;
      irq_line1_o <= 1'b0;
    end else begin
      irq_line0_o <= |(pending & ~irq_line_select_q) &&
                     irq_line_master_enable_q[0];
      irq_line1_o <= |(pending & irq_line_select_q) &&
                     irq_line_master_enable_q[1];
    end
  end

  // ============================================================
  // global filter decision, registered one cycle
  function automatic cirq_pkg::cirq_dest_e nonmatch(input logic [1:0] f);
    unique case (f)
      2'h0:    nonmatch = cirq_pkg::CIRQ_STORE_FIFO0;
      2'h1:    nonmatch = cirq_pkg::CIRQ_STORE_FIFO1;
      default: nonmatch = cirq_pkg::CIRQ_DISCARD;
    endcase
  endfunction : nonmatch

  logic [1:0]           nonmatch_standard_action;
  logic [1:0]           nonmatch_extended_action;
  logic                 reject_remote_standard;
  logic                 reject_remote_extended;
  cirq_pkg::cirq_dest_e dest_d;

  assign nonmatch_standard_action =
    global_filter_config_q[`CIRQ_FILT_NM_STD_LO +: 2];
  assign nonmatch_extended_action =
    global_filter_config_q[`CIRQ_FILT_NM_EXT_LO +: 2];
  assign reject_remote_standard =
    global_filter_config_q[`CIRQ_FILT_REJ_STD_BIT];
  assign reject_remote_extended =
    global_filter_config_q[`CIRQ_FILT_REJ_EXT_BIT];

  always_comb begin
    if (frame_i.remote && !frame_i.extended && reject_remote_standard) begin
      dest_d = cirq_pkg::CIRQ_DISCARD;
    end else if (frame_i.remote && frame_i.extended &&
                 reject_remote_extended) begin
      dest_d = cirq_pkg::CIRQ_DISCARD;
    end else if (frame_i.matched) begin
      dest_d = frame_i.match_fifo1 ? cirq_pkg::CIRQ_STORE_FIFO1
                                   : cirq_pkg::CIRQ_STORE_FIFO0;
    end else if (frame_i.extended) begin
      dest_d = nonmatch(nonmatch_extended_action);
    end else begin
      dest_d = nonmatch(nonmatch_standard_action);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      verdict_o <= '0;
    end else begin
      verdict_o.valid <= frame_i.valid;
      verdict_o.dest  <= dest_d;
    end
  end

endmodule : cirq_top

`default_nettype wire

// ### cirq_top_monitor.sv
// checker of bus, routing and filter relations at the top ports
`timescale 1ns/1ns
`default_nettype none
module cirq_top_monitor #(
  parameter int FLAGS = 30
) (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [7:0]              wb_adr_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire logic                    wb_err_o,
  input wire logic [FLAGS-1:0]        flag_set_i,
  input wire cirq_pkg::cirq_frame_s   frame_i,
  input wire cirq_pkg::cirq_verdict_s verdict_o,
  input wire logic                    irq_line0_o,
  input wire logic                    irq_line1_o
);
  logic mapped;
  logic rd_ack;
  assign mapped = wb_adr_i inside {8'h18, 8'h50, 8'h54, 8'h58, 8'h5C, 8'h80};
  assign rd_ack = wb_ack_o && !wb_we_i;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ============================================================
  // bus answers
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  a_ack_mapped: assert property (s_req ##0 mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acked");
  a_err_unmapped: assert property (s_req ##0 !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_mask_resv_zero: assert property (rd_ack && wb_adr_i inside {8'h54, 8'h58}
    |-> wb_dat_o[31:30] == 2'h0)
    else $error("reserved select or enable bits set");
  a_line_en_resv: assert property (rd_ack && wb_adr_i == 8'h5C |-> wb_dat_o[31:2] == 30'h0)
    else $error("reserved line enable bits set");
  a_filt_resv_zero: assert property (rd_ack && wb_adr_i == 8'h80 |-> wb_dat_o[31:6] == 26'h0)
    else $error("reserved filter bits set");
  // ============================================================
  // filter verdict and interrupt lines
  a_verdict_valid: assert property (frame_i.valid |=> verdict_o.valid)
    else $error("verdict missing");
  a_match_route: assert property (frame_i.valid && frame_i.matched && !frame_i.remote
    |=> verdict_o.dest == ($past(frame_i.match_fifo1) ? cirq_pkg::CIRQ_STORE_FIFO1
                                                      : cirq_pkg::CIRQ_STORE_FIFO0))
    else $error("matched frame misrouted");
  a_irq_cause: assert property ($rose(irq_line0_o) || $rose(irq_line1_o)
    |-> $past(|flag_set_i, 2) || $past(wb_ack_o && wb_we_i))
    else $error("irq line rose without cause");
  a_irq_fall: assert property ($fell(irq_line0_o) || $fell(irq_line1_o)
    |-> $past(wb_ack_o && wb_we_i))
    else $error("irq line fell without write");
  a_reset_quiet: assert property ($rose(arst_n) |-> !irq_line0_o && !irq_line1_o)
    else $error("irq line high after reset");
endmodule : cirq_top_monitor
`default_nettype wire

// ### cirq_frame_src.sv
// frame source standing in for the bus-side receive path
`timescale 1ns/1ns
`default_nettype none
module cirq_frame_src (
  input wire logic                  clk,
  input wire logic                  arst_n,
  input wire cirq_pkg::cirq_frame_s nxt,
  output cirq_pkg::cirq_frame_s     frame
);
  // idle fields flip each cycle so stale contents never look steady
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) frame <= '0;
    else if (nxt.valid) frame <= nxt;
    else frame <= {1'b0, ~frame[3:0]};
  end
endmodule : cirq_frame_src
`default_nettype wire

// ### cirq_top_test.sv
// testbench: register access, interrupt routing and filter verdicts
`timescale 1ns/1ns
`default_nettype none
module cirq_top_test;
  logic                    clk = 1'b0, arst_n = 1'b0;
  logic                    cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]              adr = 8'h00;
  logic [3:0]              sel = 4'h0;
  logic [31:0]             wdat = 32'h0, rdat, q;
  logic                    ack, err, e, l0, l1;
  logic [29:0]             fl = 30'h0;
  cirq_pkg::cirq_frame_s   nxt = '0, frame;
  cirq_pkg::cirq_verdict_s verdict;
  int                      err_count = 0, tests_run = 0, cyc_n = 0;
  always #2 clk = ~clk;
  cirq_frame_src u_src (.clk(clk), .arst_n(arst_n), .nxt(nxt), .frame(frame));
  cirq_top DUT (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .flag_set_i(fl),
    .frame_i(frame), .verdict_o(verdict), .irq_line0_o(l0), .irq_line1_o(l1));
  // ============================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // request held until the edge that samples ack; the leading edge of the
  // next call leaves one idle cycle between transfers
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    do @(posedge clk); while (!(ack || err));
    q = rdat;
    e = err;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    check(q, x);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse(input int k);
    @(posedge clk);
    fl <= 30'h1 << k;
    @(posedge clk);
    fl <= 30'h0;
    tick(1);
  endtask : pulse
  task automatic vchk(input cirq_pkg::cirq_frame_s f, input logic [1:0] x);
    @(posedge clk);
    nxt <= f;
    @(posedge clk);
    nxt <= '0;
    tick(1);
    check(32'(verdict), 32'({1'b1, x}));
  endtask : vchk
  // ============================================================
  // sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h58, 32'h0);
    rd(8'h5C, 32'h0);
    rd(8'h80, 32'h0);
    rd(8'h54, 32'h0);
    wb(1'b1, 8'h58, 32'hFFFF_FFFF);
    rd(8'h58, 32'h3FFF_FFFF);
    wb(1'b1, 8'h54, 32'hFFFF_FFFF);
    rd(8'h54, 32'h3FFF_FFFF);
    wb(1'b1, 8'h5C, 32'hFFFF_FFFF);
    rd(8'h5C, 32'h3);
    wb(1'b0, 8'h04, 32'h0);
    check(32'(e), 32'h1);
    wb(1'b1, 8'h80, 32'h3F);
    rd(8'h80, 32'h0);
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b1, 8'h80, 32'h3F);
    rd(8'h80, 32'h0);
    wb(1'b1, 8'h18, 32'h3);
    wb(1'b1, 8'h80, 32'hFFFF_FFFF);
    rd(8'h80, 32'h3F);
    // every action code, both id types, remote with and without reject
    for (int i = 0; i < 32; i++) begin
      wb(1'b1, 8'h80, 32'(i[2:1]) * 32'h14 | (i[4] ? (i[0] ? 32'h1 : 32'h2) : 32'h0));
      vchk(cirq_pkg::cirq_frame_s'{1'b1, i[0], i[3], 1'b0, 1'b0},
           (i[3] && i[4]) || i[2] ? 2'h2 : 2'(i[2:1]));
    end
    vchk(cirq_pkg::cirq_frame_s'{1'b1, 1'b0, 1'b0, 1'b1, 1'b1}, 2'h1);
    // odd flags to line 1, even flags to line 0
    wb(1'b1, 8'h58, 32'h2AAA_AAAA);
    for (int k = 0; k < 30; k++) begin
      pulse(k);
      check(32'({l0, l1}), 32'({~k[0], k[0]}));
      wb(1'b1, 8'h50, 32'h1 << k);
      tick(1);
      check(32'({l0, l1}), 32'h0);
    end
    wb(1'b1, 8'h54, 32'h0);
    pulse(3);
    check(32'({l0, l1}), 32'h0);
    rd(8'h50, 32'h8);
    wb(1'b1, 8'h54, 32'h8);
    tick(1);
    check(32'({l0, l1}), 32'h1);
    wb(1'b1, 8'h5C, 32'h1);
    tick(1);
    check(32'({l0, l1}), 32'h0);
    stop_test();
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      err_count++;
      stop_test();
    end
  end
endmodule : cirq_top_test
bind cirq_top cirq_top_monitor #(.FLAGS(FLAGS)) u_mon (.clk(clk), .arst_n(arst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .flag_set_i(flag_set_i), .frame_i(frame_i), .verdict_o(verdict_o),
  .irq_line0_o(irq_line0_o), .irq_line1_o(irq_line1_o));
`default_nettype wire
